// file: hw/acq_regs_pkg.sv
// Package: offsets, field positions, reset values and carriers for the
// sample readout, front-end control and digital port register block.
// Assumes a 32-bit register access port with byte offsets.
package acq_regs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_SAMPLE_READOUT   = 8'h30;
  localparam logic [7:0] OFF_FE_CTRL_LOW      = 8'h38;
  localparam logic [7:0] OFF_FE_CTRL_HIGH     = 8'h3C;
  localparam logic [7:0] OFF_IRQ_STATUS       = 8'h40;
  localparam logic [7:0] OFF_DIGITAL_LEVELS   = 8'h44;
  localparam logic [7:0] OFF_DIGITAL_DIR_ALT  = 8'h48;

  // Sample readout word fields
  localparam int SAMPLE_INVALID_BIT = 31;
  localparam int SAMPLE_RUNNING_BIT = 30;
  localparam int SAMPLE_SRC_LSB     = 20;
  localparam int SAMPLE_DIFF_BIT    = 19;
  localparam int SAMPLE_GAIN_LSB    = 16;
  localparam int SAMPLE_COUNTS_LSB  = 0;

  // Front-end control writable bits: config, go, input, com, gain,
  // mux, sequencer, temperature, cms
  localparam logic [31:0] FE_CTRL_WRITE_MASK = 32'h0003_7BFA;
  localparam logic [31:0] FE_CTRL_RESET      = 32'h0000_0000;

  // Digital port direction and secondary function bits
  localparam int DIR_LINE_ZERO_BIT      = 0;
  localparam int DIR_LINE_ONE_BIT       = 1;
  localparam int START_ENABLE_BIT       = 18;
  localparam int START_EDGE_BIT         = 19;
  localparam int IRQ_PIN_ENABLE_BIT     = 22;
  localparam int IRQ_PIN_EDGE_BIT       = 23;
  localparam logic [31:0] DIR_ALT_WRITE_MASK = 32'h00CC_0003;
  localparam logic [31:0] DIR_ALT_RESET      = 32'h0000_0000;
  localparam logic [1:0]  LEVELS_RESET       = 2'h0;

  // Status bits latched by the secondary pin functions
  localparam int STATUS_EXT_IRQ_BIT    = 16;
  localparam int STATUS_CONV_START_BIT = 17;

  // Answer to an unmapped offset
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // One converted sample with its status
  typedef struct packed {
    logic [2:0]  sample_source_input;
    logic        diff;
    logic [2:0]  sample_gain_code;
    logic [15:0] counts;
  } sample_t;

  // Decoded front-end control fields
  typedef struct packed {
    logic       config_en;
    logic       go;
    logic [2:0] input_sel;
    logic       com;
    logic [2:0] gain;
    logic       mux_n;
    logic [1:0] seq;
    logic       temp_n;
    logic       cms;
  } fe_ctrl_t;

endpackage

// file: hw/sample_fifo.sv
// Sample FIFO: parameterised width and depth, valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  // Honest full and empty from the entry count
  assign in_ready  = (count_reg != DEPTH[PW:0]);
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr_reg];
  assign level     = count_reg;

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers wrap at the depth
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
      end
    end
  end

  // Entry count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= (PW+1)'(count_reg + 1'b1);
    end else if (pop && !push) begin
      count_reg <= (PW+1)'(count_reg - 1'b1);
    end
  end

endmodule

// file: hw/acq_sample_readout_dio_regs.sv
// Register block: sample readout word, two front-end control registers,
// two-line digital port and the secondary pin functions.
// Assumes a simple 32-bit register port decoded from host memory space,
// a sample stream from the converter side and synchronous pin inputs.
`timescale 1ns/1ps
module acq_sample_readout_dio_regs #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // Register access port
  input  wire logic                       reg_rd,
  input  wire logic                       reg_wr,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [31:0]                reg_wdata,
  output logic [31:0]                     reg_rdata,
  output logic                            reg_rvalid,
  // Sample stream from the converters
  input  wire logic                       sample_valid,
  output logic                            sample_ready,
  input  wire acq_regs_pkg::sample_t      sample_data,
  input  wire logic                       seq_running,
  // Front-end control towards the two converters
  output acq_regs_pkg::fe_ctrl_t          fe_ctrl_low,
  output acq_regs_pkg::fe_ctrl_t          fe_ctrl_high,
  // Digital port lines
  input  wire logic                       digital_line_zero_in,
  output logic                            digital_line_zero_out,
  output logic                            digital_line_zero_oe,
  input  wire logic                       digital_line_one_in,
  output logic                            digital_line_one_out,
  output logic                            digital_line_one_oe,
  // Secondary function inputs and their events
  input  wire logic                       irq_input_line,
  input  wire logic                       conv_start_input_line,
  output logic                            ext_irq_event,
  output logic                            conv_start_event,
  output logic                            ext_irq_status_bit,
  output logic                            conv_start_status_bit
);

  localparam int SW = $bits(acq_regs_pkg::sample_t);

  // Address decode strobes
  logic rd_readout;
  logic wr_fe_low;
  logic wr_fe_high;
  logic wr_status;
  logic wr_levels;
  logic wr_dir_alt;

  // Register state
  logic [31:0] fe_ctrl_reg [2];
  logic [1:0]  levels_reg;
  logic [31:0] dir_alt_reg;
  logic        ext_irq_status_reg;
  logic        conv_start_status_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;

  // Pin history for edge detection
  logic irq_line_prev_reg;
  logic start_line_prev_reg;
  logic irq_edge;
  logic start_edge;

  // FIFO head
  logic                  head_valid;
  acq_regs_pkg::sample_t head_data;
  logic [SW-1:0]         head_bits;
  logic                  pop;

  // Readout word pieces
  logic [31:0] readout_word;
  logic [1:0]  dir_bits;
  logic [1:0]  pin_bits;
  logic [1:0]  levels_read;

  // Strobes for each register
  assign rd_readout = reg_rd && (reg_addr == acq_regs_pkg::OFF_SAMPLE_READOUT);
  assign wr_fe_low  = reg_wr && (reg_addr == acq_regs_pkg::OFF_FE_CTRL_LOW);
  assign wr_fe_high = reg_wr && (reg_addr == acq_regs_pkg::OFF_FE_CTRL_HIGH);
  assign wr_status  = reg_wr && (reg_addr == acq_regs_pkg::OFF_IRQ_STATUS);
  assign wr_levels  = reg_wr && (reg_addr == acq_regs_pkg::OFF_DIGITAL_LEVELS);
  assign wr_dir_alt = reg_wr && (reg_addr == acq_regs_pkg::OFF_DIGITAL_DIR_ALT);

  // Sample buffer between converter stream and readout register
  sample_fifo #(
    .WIDTH (SW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .ref_clk   (ref_clk),
    .rst_n     (rst_n),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (head_valid),
    .out_ready (pop),
    .out_data  (head_bits),
    .level     ()
  );

  assign head_data = acq_regs_pkg::sample_t'(head_bits);

  // Only a read that finds an entry consumes it
  assign pop = rd_readout && head_valid;

  // Readout word assembly
  always_comb begin
    readout_word = 32'h0000_0000;
    readout_word[acq_regs_pkg::SAMPLE_RUNNING_BIT] = seq_running;
    if (!head_valid) begin
      // Empty: only the flags carry meaning
      readout_word[acq_regs_pkg::SAMPLE_INVALID_BIT] = 1'b1;
    end else begin
      readout_word[acq_regs_pkg::SAMPLE_SRC_LSB +: 3] =
        head_data.sample_source_input;
      readout_word[acq_regs_pkg::SAMPLE_DIFF_BIT] = head_data.diff;
      // Reserved code six is passed on as taken, not filtered
      readout_word[acq_regs_pkg::SAMPLE_GAIN_LSB +: 3] =
        head_data.sample_gain_code;
      readout_word[acq_regs_pkg::SAMPLE_COUNTS_LSB +: 16] = head_data.counts;
    end
  end

  // Two front-end control banks of identical layout
  generate
    for (genvar b = 0; b < 2; b++) begin : g_fe_bank
      logic bank_wr;
      assign bank_wr = (b == 0) ? wr_fe_low : wr_fe_high;
      // Reserved bits are never stored, so they read back as zero
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          fe_ctrl_reg[b] <= acq_regs_pkg::FE_CTRL_RESET;
        end else if (bank_wr) begin
          fe_ctrl_reg[b] <= reg_wdata & acq_regs_pkg::FE_CTRL_WRITE_MASK;
        end
      end
    end
  endgenerate

  // Field view of each bank towards its converter
  function automatic acq_regs_pkg::fe_ctrl_t fe_fields(input logic [31:0] r);
    acq_regs_pkg::fe_ctrl_t f;
    f.config_en = r[17];
    f.go        = r[16];
    f.input_sel = r[14:12];
    f.com       = r[11];
    f.gain      = r[9:7];
    f.mux_n     = r[6];
    f.seq       = r[5:4];
    f.temp_n    = r[3];
    f.cms       = r[1];
    return f;
  endfunction

  // Low bank serves inputs 0 to 7, high bank inputs 8 to 15
  assign fe_ctrl_low  = fe_fields(fe_ctrl_reg[0]);
  assign fe_ctrl_high = fe_fields(fe_ctrl_reg[1]);

  // Output latch of the digital port
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      levels_reg <= acq_regs_pkg::LEVELS_RESET;
    end else if (wr_levels) begin
      levels_reg <= reg_wdata[1:0];
    end
  end

  // Direction and secondary function control
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_alt_reg <= acq_regs_pkg::DIR_ALT_RESET;
    end else if (wr_dir_alt) begin
      dir_alt_reg <= reg_wdata & acq_regs_pkg::DIR_ALT_WRITE_MASK;
    end
  end

  assign dir_bits[0] = dir_alt_reg[acq_regs_pkg::DIR_LINE_ZERO_BIT];
  assign dir_bits[1] = dir_alt_reg[acq_regs_pkg::DIR_LINE_ONE_BIT];
  assign pin_bits    = {digital_line_one_in, digital_line_zero_in};

  // Lines drive the latch only while set as outputs
  assign digital_line_zero_oe  = dir_bits[0];
  assign digital_line_one_oe   = dir_bits[1];
  assign digital_line_zero_out = levels_reg[0];
  assign digital_line_one_out  = levels_reg[1];

  // Per line: latch for outputs, pin level for inputs
  assign levels_read = (levels_reg & dir_bits) | (pin_bits & ~dir_bits);

  // Previous pin samples for edge detection
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_line_prev_reg   <= 1'b0;
      start_line_prev_reg <= 1'b0;
    end else begin
      irq_line_prev_reg   <= irq_input_line;
      start_line_prev_reg <= conv_start_input_line;
    end
  end

  // Edge choice per function: set rising, clear falling
  assign irq_edge = dir_alt_reg[acq_regs_pkg::IRQ_PIN_EDGE_BIT] ?
                    (irq_input_line && !irq_line_prev_reg) :
                    (!irq_input_line && irq_line_prev_reg);
  assign start_edge = dir_alt_reg[acq_regs_pkg::START_EDGE_BIT] ?
                      (conv_start_input_line && !start_line_prev_reg) :
                      (!conv_start_input_line && start_line_prev_reg);

  // Events only while the function is enabled
  assign ext_irq_event =
    irq_edge && dir_alt_reg[acq_regs_pkg::IRQ_PIN_ENABLE_BIT];
  assign conv_start_event =
    start_edge && dir_alt_reg[acq_regs_pkg::START_ENABLE_BIT];

  // Sticky status; a new edge wins over a write-one clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_irq_status_reg <= 1'b0;
    end else if (ext_irq_event) begin
      ext_irq_status_reg <= 1'b1;
    end else if (wr_status && reg_wdata[acq_regs_pkg::STATUS_EXT_IRQ_BIT]) begin
      ext_irq_status_reg <= 1'b0;
    end
  end

  // Start status, same set-over-clear policy
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_start_status_reg <= 1'b0;
    end else if (conv_start_event) begin
      conv_start_status_reg <= 1'b1;
    end else if (wr_status && reg_wdata[acq_regs_pkg::STATUS_CONV_START_BIT]) begin
      conv_start_status_reg <= 1'b0;
    end
  end

  assign ext_irq_status_bit    = ext_irq_status_reg;
  assign conv_start_status_bit = conv_start_status_reg;

  // Read data selection
  always_comb begin
    rdata_next = acq_regs_pkg::UNMAPPED_READ;
    if (reg_addr == acq_regs_pkg::OFF_SAMPLE_READOUT) begin
      rdata_next = readout_word;
    end else if (reg_addr == acq_regs_pkg::OFF_FE_CTRL_LOW) begin
      rdata_next = fe_ctrl_reg[0];
    end else if (reg_addr == acq_regs_pkg::OFF_FE_CTRL_HIGH) begin
      rdata_next = fe_ctrl_reg[1];
    end else if (reg_addr == acq_regs_pkg::OFF_IRQ_STATUS) begin
      rdata_next[acq_regs_pkg::STATUS_EXT_IRQ_BIT]    = ext_irq_status_reg;
      rdata_next[acq_regs_pkg::STATUS_CONV_START_BIT] = conv_start_status_reg;
    end else if (reg_addr == acq_regs_pkg::OFF_DIGITAL_LEVELS) begin
      rdata_next[1:0] = levels_read;
    end else if (reg_addr == acq_regs_pkg::OFF_DIGITAL_DIR_ALT) begin
      rdata_next = dir_alt_reg;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= 32'h0000_0000;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= reg_rd;
      if (reg_rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign reg_rdata  = rdata_reg;
  assign reg_rvalid = rvalid_reg;

endmodule

// file: test/acq_regs_checker_props.sv
// Checker: port relations of the register block, bound to its top module.
// Assumes one clock domain, the package offsets and a one-cycle read answer.
`timescale 1ns/1ps
module acq_regs_checker #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic                   ref_clk,
  input wire logic                   rst_n,
  input wire logic                   reg_rd,
  input wire logic                   reg_wr,
  input wire logic [7:0]             reg_addr,
  input wire logic [31:0]            reg_wdata,
  input wire logic [31:0]            reg_rdata,
  input wire logic                   reg_rvalid,
  input wire logic                   seq_running,
  input wire acq_regs_pkg::fe_ctrl_t fe_ctrl_low,
  input wire acq_regs_pkg::fe_ctrl_t fe_ctrl_high,
  input wire logic                   digital_line_zero_in,
  input wire logic                   digital_line_zero_out,
  input wire logic                   digital_line_zero_oe,
  input wire logic                   irq_input_line,
  input wire logic                   conv_start_input_line,
  input wire logic                   ext_irq_event,
  input wire logic                   conv_start_event,
  input wire logic                   ext_irq_status_bit
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [13:0] fe_w;
  // Write data gathered into the front-end field order
  assign fe_w = {reg_wdata[17:16], reg_wdata[14:11], reg_wdata[9:3], reg_wdata[1]};
  // Readout request followed by its answer
  sequence s_rd_readout;
    reg_rd && reg_addr == acq_regs_pkg::OFF_SAMPLE_READOUT ##1 reg_rvalid;
  endsequence
  property p_invalid_clean;
    s_rd_readout ##0 reg_rdata[31] |-> reg_rdata[29:0] == 30'h0;
  endproperty
  a_invalid_clean: assert property (p_invalid_clean) else $error("dirty invalid word");
  property p_running;
    s_rd_readout |-> reg_rdata[30] == $past(seq_running);
  endproperty
  a_running: assert property (p_running) else $error("running bit wrong");
  property p_fe_low;
    reg_wr && reg_addr == acq_regs_pkg::OFF_FE_CTRL_LOW |=>
      fe_ctrl_low == $past(fe_w) && $stable(fe_ctrl_high);
  endproperty
  a_fe_low: assert property (p_fe_low) else $error("low bank fields wrong");
  property p_oe;
    reg_wr && reg_addr == acq_regs_pkg::OFF_DIGITAL_DIR_ALT |=>
      digital_line_zero_oe == $past(reg_wdata[0]);
  endproperty
  a_oe: assert property (p_oe) else $error("direction not applied");
  property p_out;
    reg_wr && reg_addr == acq_regs_pkg::OFF_DIGITAL_LEVELS && digital_line_zero_oe |=>
      digital_line_zero_out == $past(reg_wdata[0]);
  endproperty
  a_out: assert property (p_out) else $error("output latch wrong");
  property p_pin_read;
    reg_rd && reg_addr == acq_regs_pkg::OFF_DIGITAL_LEVELS && !digital_line_zero_oe |=>
      reg_rdata[0] == $past(digital_line_zero_in);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("input pin not read");
  property p_irq_event;
    ext_irq_event |-> irq_input_line != $past(irq_input_line);
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("irq event without edge");
  property p_start_event;
    conv_start_event |-> conv_start_input_line != $past(conv_start_input_line);
  endproperty
  a_start_event: assert property (p_start_event) else $error("start without edge");
  property p_irq_status;
    ext_irq_event |=> ext_irq_status_bit;
  endproperty
  a_irq_status: assert property (p_irq_status) else $error("status not latched");
endmodule

bind acq_sample_readout_dio_regs acq_regs_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .ref_clk, .rst_n, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
  .seq_running, .fe_ctrl_low, .fe_ctrl_high, .digital_line_zero_in, .digital_line_zero_out,
  .digital_line_zero_oe, .irq_input_line, .conv_start_input_line, .ext_irq_event,
  .conv_start_event, .ext_irq_status_bit);

// file: test/sample_source.sv
// Converter-side model: queues samples and offers them on valid/ready.
// Assumes the FIFO takes a sample at a rising edge with both high.
`timescale 1ns/1ps
module sample_source (
  input  wire logic             ref_clk,
  input  wire logic             sample_ready,
  output logic                  sample_valid,
  output acq_regs_pkg::sample_t sample_data
);
  acq_regs_pkg::sample_t q[$];
  initial begin
    sample_valid = 1'b0;
    sample_data  = '0;
  end
  // Pops on handshake, then offers the next entry or a scrambled idle word
  always @(posedge ref_clk) begin
    if (sample_valid && sample_ready)
      void'(q.pop_front());
    #10;
    sample_valid = (q.size() != 0);
    sample_data  = (q.size() != 0) ? q[0] : ~sample_data;
  end
endmodule

// file: test/test_acq_sample_readout_dio_regs.sv
// Testbench: register access sequences with expected values for the block.
// Assumes the package offsets and the converter-side model in sample_source.
`timescale 1ns/1ps
module test_acq_sample_readout_dio_regs;
  logic                  ref_clk, rst_n, reg_rd, reg_wr, reg_rvalid, seq_running;
  logic                  sample_valid, sample_ready, irq_input_line, conv_start_input_line;
  logic                  digital_line_zero_in, digital_line_zero_out, digital_line_zero_oe;
  logic                  digital_line_one_in, digital_line_one_out, digital_line_one_oe;
  logic                  ext_irq_event, conv_start_event, ext_irq_status_bit;
  logic                  conv_start_status_bit;
  logic [7:0]            reg_addr;
  logic [31:0]           reg_wdata, reg_rdata;
  acq_regs_pkg::sample_t sample_data;
  acq_regs_pkg::fe_ctrl_t fe_ctrl_low, fe_ctrl_high;
  acq_regs_pkg::sample_t smp [9];
  logic [7:0]            offs [6] = '{8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h50};
  int                    n_fail, checks_done;

  acq_sample_readout_dio_regs #(.FIFO_DEPTH(8)) dut_u (
    .ref_clk, .rst_n, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
    .sample_valid, .sample_ready, .sample_data, .seq_running, .fe_ctrl_low, .fe_ctrl_high,
    .digital_line_zero_in, .digital_line_zero_out, .digital_line_zero_oe,
    .digital_line_one_in, .digital_line_one_out, .digital_line_one_oe,
    .irq_input_line, .conv_start_input_line, .ext_irq_event, .conv_start_event,
    .ext_irq_status_bit, .conv_start_status_bit);
  sample_source ss_u (.ref_clk, .sample_ready, .sample_valid, .sample_data);

  // Clock at 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk) #10;
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = v;
    @(posedge ref_clk) #10;
    reg_wr = 1'b0;
  endtask

  // Read one word and compare it
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk) #10;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge ref_clk) #10;
    reg_rd = 1'b0;
    chk(reg_rvalid, 1);
    chk(reg_rdata, exp);
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the roughly 90 cycles of the run
  initial begin
    #2_000_000;
    n_fail++;
    conclude();
  end

  initial begin
    {rst_n, reg_rd, reg_wr, seq_running, irq_input_line} = 5'h0;
    {digital_line_zero_in, digital_line_one_in} = 2'h0;
    conv_start_input_line = 1'b1;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0;
    repeat (3) @(posedge ref_clk);
    #10 rst_n = 1'b1;
    // Reset values and an unmapped offset
    foreach (offs[k]) rc(offs[k], 32'h0);
    rc(acq_regs_pkg::OFF_SAMPLE_READOUT, 32'h8000_0000);
    seq_running = 1'b1;
    rc(acq_regs_pkg::OFF_SAMPLE_READOUT, 32'hC000_0000);
    // Fill the FIFO past its depth, then drain it in order
    for (int i = 0; i < 9; i++) begin
      smp[i] = '{3'h7 - i[2:0], i[1], i[2:0], 16'h7FFF + i[15:0]};
      ss_u.q.push_back(smp[i]);
    end
    repeat (12) @(posedge ref_clk);
    #10 chk(sample_ready, 0);
    for (int i = 0; i < 9; i++)
      rc(acq_regs_pkg::OFF_SAMPLE_READOUT, {2'b01, 7'h0, smp[i]});
    rc(acq_regs_pkg::OFF_SAMPLE_READOUT, 32'hC000_0000);
    // Front-end banks: low with every defined bit set, high with a mixed pattern, reserved bits written as zero
    wr(acq_regs_pkg::OFF_FE_CTRL_LOW, acq_regs_pkg::FE_CTRL_WRITE_MASK);
    wr(acq_regs_pkg::OFF_FE_CTRL_HIGH, 32'h0001_5A4A);
    rc(acq_regs_pkg::OFF_FE_CTRL_LOW, acq_regs_pkg::FE_CTRL_WRITE_MASK);
    rc(acq_regs_pkg::OFF_FE_CTRL_HIGH, 32'h0001_5A4A);
    chk(fe_ctrl_low, 32'h3FFF);
    chk(fe_ctrl_high, 32'h1B93);
    wr(acq_regs_pkg::OFF_DIGITAL_DIR_ALT, acq_regs_pkg::DIR_ALT_WRITE_MASK);
    rc(acq_regs_pkg::OFF_DIGITAL_DIR_ALT, acq_regs_pkg::DIR_ALT_WRITE_MASK);
    // Digital port: latch for outputs, pin for inputs
    {digital_line_zero_in, digital_line_one_in} = 2'h3;
    wr(acq_regs_pkg::OFF_DIGITAL_DIR_ALT, 32'h3);
    chk({digital_line_one_oe, digital_line_zero_oe}, 32'h3);
    wr(acq_regs_pkg::OFF_DIGITAL_LEVELS, 32'h2);
    chk({digital_line_one_out, digital_line_zero_out}, 32'h2);
    rc(acq_regs_pkg::OFF_DIGITAL_LEVELS, 32'h2);
    wr(acq_regs_pkg::OFF_DIGITAL_DIR_ALT, 32'h1);
    chk({digital_line_one_oe, digital_line_zero_oe}, 32'h1);
    digital_line_one_in = 1'b0;
    rc(acq_regs_pkg::OFF_DIGITAL_LEVELS, 32'h0);
    // Pin functions: irq on rising, start on falling
    wr(acq_regs_pkg::OFF_DIGITAL_DIR_ALT, 32'h00C4_0000);
    @(posedge ref_clk) #10;
    irq_input_line = 1'b1;
    #20 chk(ext_irq_event, 1);
    @(posedge ref_clk) #10;
    irq_input_line        = 1'b0;
    conv_start_input_line = 1'b0;
    #20 chk(ext_irq_event, 0);
    chk(conv_start_event, 1);
    @(posedge ref_clk) #10;
    chk(conv_start_status_bit, 1);
    rc(acq_regs_pkg::OFF_IRQ_STATUS, 32'h0003_0000);
    wr(acq_regs_pkg::OFF_IRQ_STATUS, 32'h0001_0000);
    rc(acq_regs_pkg::OFF_IRQ_STATUS, 32'h0002_0000);
    wr(acq_regs_pkg::OFF_DIGITAL_DIR_ALT, 32'h0080_0000);
    @(posedge ref_clk) #10;
    irq_input_line = 1'b1;
    #20 chk(ext_irq_event, 0);
    conclude();
  end
endmodule
